// >>> p6g_board.sv
// Board-side model of the port 6 pins: external drivers, pull-ups, clock source.
// Assumes the block's pin enables; lower pins are open-drain, floating pins toggle.
`timescale 1ns/1ps
`default_nettype none
module p6g_board (
    input  wire logic       hclk,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pull_on,
    input  wire logic [7:0] ext_val,
    input  wire logic [7:0] ext_en,
    input  wire logic       exclk_on,
    output logic      [7:0] pin_level
);
    logic [7:0] last = 8'h00;
    logic       exclk = 1'h0;
    // Source at 6.4 MHz
    // Offset keeps its edges off the hclk rising edges, so sampling is race free
    initial
    begin
        #20;
        forever #78.125 exclk = ~exclk;
    end
    // Pin resolution
    // Floating pins flip each cycle so a stale level never passes as valid
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (pin_oe[i])
                pin_level[i] = (i < 4) ? 1'h0 : pin_out[i];
            else if (i == 2 && exclk_on)
                pin_level[i] = exclk;
            else if (ext_en[i])
                pin_level[i] = ext_val[i];
            else if (pull_on[i])
                pin_level[i] = 1'h1;
            else
                pin_level[i] = ~last[i];
        end
    end
    always @(posedge hclk) last <= pin_level;
endmodule : p6g_board
`default_nettype wire

// >>> p6g_consts.svh
// Constants for the port 6 I/O block: register indices, masks, reset values.
// Assumes inclusion by name from the package and the design file.
// How it works
// - A writable output latch drives every pin set as output.
// - Each bit has its own direction bit; one means input.
// - Upper four pins get a pull-up per bit, only in input mode.
// - Lower four pins are open-drain: they drive low or release.
// - Pins 0, 1, 2 also carry serial clock, serial data, external clock.
// - Reset puts every port bit into input mode.
// - In every pull-up register, bit n controls pin n of its port.
// - A pull-up bit at zero leaves its pin without a pull-up.
// - A pull-up bit at one connects the pull-up, for input pins.
`ifndef P6G_CONSTS_SVH
`define P6G_CONSTS_SVH

// Register indices; byte address is four times the index
`define P6G_IDX_PU0      16'hff30
`define P6G_IDX_PU1      16'hff31
`define P6G_IDX_PU3      16'hff33
`define P6G_IDX_PU4      16'hff34
`define P6G_IDX_PU5      16'hff35
`define P6G_IDX_PU6      16'hff36
`define P6G_IDX_PU7      16'hff37
`define P6G_IDX_PULLUP_SELECT_PORT12     16'hff3c
`define P6G_IDX_PULLUP_SELECT_PORT14     16'hff3e
`define P6G_IDX_LATCH    16'hff06
`define P6G_IDX_DIR      16'hff26
`define P6G_IDX_ALT      16'hff46

// Implemented bits of each register; the rest read as zero
`define P6G_MASK_PU0     8'h7f
`define P6G_MASK_PU1     8'hff
`define P6G_MASK_PU3     8'h0f
`define P6G_MASK_PU4     8'h0f
`define P6G_MASK_PU5     8'h0f
`define P6G_MASK_PU6     8'hf0
`define P6G_MASK_PU7     8'hff
`define P6G_MASK_PULLUP_SELECT_PORT12    8'h01
`define P6G_MASK_PULLUP_SELECT_PORT14    8'h03
`define P6G_MASK_ALT     8'h07

`define P6G_RST_PU       8'h00
`define P6G_RST_LATCH    8'h00
`define P6G_RST_DIR      8'hff
`define P6G_RST_ALT      8'h00

// Alternate function bit positions
`define P6G_BIT_SCL      0
`define P6G_BIT_SDA      1
`define P6G_BIT_EXCLK    2

// AHB transfer type
`define P6G_HTRANS_NONSEQ 2'h2

`endif

// >>> p6g_pkg.sv
// Types shared by the port 6 I/O block.
// Assumes p6g_consts.svh is on the include path.
`include "p6g_consts.svh"

package p6g_pkg;

    // Register selected by a bus address
    typedef enum logic [3:0] {
        P6G_SEL_PU0,
        P6G_SEL_PU1,
        P6G_SEL_PU3,
        P6G_SEL_PU4,
        P6G_SEL_PU5,
        P6G_SEL_PU7,
        P6G_SEL_PULLUP_SELECT_PORT12,
        P6G_SEL_PULLUP_SELECT_PORT14,
        P6G_SEL_PU6,
        P6G_SEL_LATCH,
        P6G_SEL_DIR,
        P6G_SEL_ALT,
        P6G_SEL_PORT,
        P6G_SEL_NONE
    } p6g_sel_e;

    typedef logic [7:0] p6g_byte_t;

endpackage : p6g_pkg

// >>> p6g_port6.sv
// Port 6 general-purpose I/O with pull-up option bank, AHB-Lite slave.
// Assumes one clock, hclk; pins come from the board and are synchronised here.
// Serial peripheral signals are on hclk and need no synchroniser.
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "p6g_consts.svh"

module p6g_port6 (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              clk_en,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic [7:0]        port_pin_in,
    output logic      [7:0]        port_pin_out,
    output logic      [7:0]        port_pin_oe,
    output logic      [7:0]        port_pullup_on,
    input  wire logic              serial_clock_out,
    input  wire logic              serial_data_out,
    output logic                   serial_clock_in,
    output logic                   serial_data_in,
    output logic                   ext_serial_clock_input,
    output p6g_pkg::p6g_byte_t     pullup_port0,
    output p6g_pkg::p6g_byte_t     pullup_port1,
    output p6g_pkg::p6g_byte_t     pullup_port3,
    output p6g_pkg::p6g_byte_t     pullup_port4,
    output p6g_pkg::p6g_byte_t     pullup_port5,
    output p6g_pkg::p6g_byte_t     pullup_port7,
    output p6g_pkg::p6g_byte_t     pullup_port12,
    output p6g_pkg::p6g_byte_t     pullup_port14
);
    import p6g_pkg::*;

    localparam int BANK_N = 8;

    // Address decode, shared by the read path and the write path
    function automatic p6g_sel_e decode_sel(input logic [31:0] addr);
        p6g_sel_e s;
        s = P6G_SEL_NONE;
        if (addr[31:18] == 14'h0000 && addr[1:0] == 2'h0)
        begin
            case (addr[17:2])
                `P6G_IDX_PU0:   s = P6G_SEL_PU0;
                `P6G_IDX_PU1:   s = P6G_SEL_PU1;
                `P6G_IDX_PU3:   s = P6G_SEL_PU3;
                `P6G_IDX_PU4:   s = P6G_SEL_PU4;
                `P6G_IDX_PU5:   s = P6G_SEL_PU5;
                `P6G_IDX_PU7:   s = P6G_SEL_PU7;
                `P6G_IDX_PULLUP_SELECT_PORT12:  s = P6G_SEL_PULLUP_SELECT_PORT12;
                `P6G_IDX_PULLUP_SELECT_PORT14:  s = P6G_SEL_PULLUP_SELECT_PORT14;
                `P6G_IDX_PU6:   s = P6G_SEL_PU6;
                `P6G_IDX_LATCH: s = P6G_SEL_LATCH;
                `P6G_IDX_DIR:   s = P6G_SEL_DIR;
                `P6G_IDX_ALT:   s = P6G_SEL_ALT;
                default:        s = P6G_SEL_NONE;
            endcase
        end
        return s;
    endfunction : decode_sel

    // Implemented bits per pull-up bank slot
    function automatic p6g_byte_t bank_mask(input logic [2:0] idx);
        p6g_byte_t m;
        case (idx)
            3'h0:    m = `P6G_MASK_PU0;
            3'h1:    m = `P6G_MASK_PU1;
            3'h2:    m = `P6G_MASK_PU3;
            3'h3:    m = `P6G_MASK_PU4;
            3'h4:    m = `P6G_MASK_PU5;
            3'h5:    m = `P6G_MASK_PU7;
            3'h6:    m = `P6G_MASK_PULLUP_SELECT_PORT12;
            default: m = `P6G_MASK_PULLUP_SELECT_PORT14;
        endcase
        return m;
    endfunction : bank_mask

    // Bus state
    logic                   wr_pend;
    p6g_sel_e               wr_sel;
    logic                   next_wr_pend;
    p6g_sel_e               next_wr_sel;
    logic [31:0]            next_hrdata;
    p6g_sel_e               addr_sel;
    logic                   addr_take;

    // Register state
    p6g_byte_t              pu_bank [BANK_N];
    p6g_byte_t              next_pu_bank [BANK_N];
    p6g_byte_t              pu6;
    p6g_byte_t              latch;
    p6g_byte_t              dir;
    p6g_byte_t              alt;
    p6g_byte_t              next_pu6;
    p6g_byte_t              next_latch;
    p6g_byte_t              next_dir;
    p6g_byte_t              next_alt;

    // Pin state
    logic [7:0]             pin_meta;
    logic [7:0]             pin_sync;
    p6g_byte_t              port_view;
    logic [7:0]             drive_level;
    logic [7:0]             next_pin_out;
    logic [7:0]             next_pin_oe;
    logic [7:0]             next_pullup_on;

    assign addr_sel  = decode_sel(haddr);
    assign addr_take = hsel && hready && (htrans == `P6G_HTRANS_NONSEQ);

    // Port read view
    // port read view
    assign port_view = (pin_sync & dir) | (latch & ~dir);

    always_comb
    begin
        next_wr_pend = wr_pend;
        next_wr_sel  = wr_sel;
        next_hrdata  = hrdata;
        if (hready)
        begin
            next_wr_pend = addr_take && hwrite;
            next_wr_sel  = addr_sel;
        end
        if (addr_take && !hwrite)
        begin
            next_hrdata = 32'h0000_0000;
            case (addr_sel)
                P6G_SEL_PU0, P6G_SEL_PU1, P6G_SEL_PU3, P6G_SEL_PU4,
                P6G_SEL_PU5, P6G_SEL_PU7, P6G_SEL_PULLUP_SELECT_PORT12, P6G_SEL_PULLUP_SELECT_PORT14:
                    next_hrdata[7:0] = pu_bank[addr_sel[2:0]];
                P6G_SEL_PU6:   next_hrdata[7:0] = pu6;
                P6G_SEL_LATCH: next_hrdata[7:0] = port_view;
                P6G_SEL_DIR:   next_hrdata[7:0] = dir;
                P6G_SEL_ALT:   next_hrdata[7:0] = alt;
                default:       next_hrdata = 32'h0000_0000;
            endcase
        end
    end

    // Register writes land in the data phase
    always_comb
    begin
        next_pu6   = pu6;
        next_latch = latch;
        next_dir   = dir;
        next_alt   = alt;
        for (int k = 0; k < BANK_N; k++)
        begin
            next_pu_bank[k] = pu_bank[k];
        end
        if (wr_pend)
        begin
            case (wr_sel)
                P6G_SEL_PU0, P6G_SEL_PU1, P6G_SEL_PU3, P6G_SEL_PU4,
                P6G_SEL_PU5, P6G_SEL_PU7, P6G_SEL_PULLUP_SELECT_PORT12, P6G_SEL_PULLUP_SELECT_PORT14:
                    next_pu_bank[wr_sel[2:0]] = hwdata[7:0] & bank_mask(wr_sel[2:0]);
                P6G_SEL_PU6:   next_pu6   = hwdata[7:0] & `P6G_MASK_PU6;
                P6G_SEL_LATCH: next_latch = hwdata[7:0];
                P6G_SEL_DIR:   next_dir   = hwdata[7:0];
                P6G_SEL_ALT:   next_alt   = hwdata[7:0] & `P6G_MASK_ALT;
                default:       next_latch = latch;
            endcase
        end
    end

    // Pin drive per bit
    genvar i;
    generate
        for (i = 0; i < 8; i++)
        begin : g_pin
            if (i == `P6G_BIT_SCL)
            begin : g_scl
                assign drive_level[i] = alt[i] ? (latch[i] & serial_clock_out) : latch[i];
            end
            else if (i == `P6G_BIT_SDA)
            begin : g_sda
                assign drive_level[i] = alt[i] ? (latch[i] & serial_data_out) : latch[i];
            end
            else
            begin : g_gp
                assign drive_level[i] = latch[i];
            end
            if (i < 4)
            begin : g_od
                assign next_pin_out[i]   = 1'b0;
                assign next_pin_oe[i]    = !dir[i] && !drive_level[i];
                assign next_pullup_on[i] = 1'b0;
            end
            else
            begin : g_pp
                assign next_pin_out[i]   = drive_level[i];
                assign next_pin_oe[i]    = !dir[i];
                assign next_pullup_on[i] = pu6[i] && dir[i];
            end
        end
    endgenerate

    // Bus registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend   <= 1'b0;
            wr_sel    <= P6G_SEL_NONE;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end
        else if (clk_en)
        begin
            wr_pend   <= next_wr_pend;
            wr_sel    <= next_wr_sel;
            hrdata    <= next_hrdata;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Configuration registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pu6   <= `P6G_RST_PU;
            latch <= `P6G_RST_LATCH;
            dir   <= `P6G_RST_DIR;
            alt   <= `P6G_RST_ALT;
            for (int k = 0; k < BANK_N; k++)
            begin
                pu_bank[k] <= `P6G_RST_PU;
            end
        end
        else if (clk_en)
        begin
            pu6   <= next_pu6;
            latch <= next_latch;
            dir   <= next_dir;
            alt   <= next_alt;
            for (int k = 0; k < BANK_N; k++)
            begin
                pu_bank[k] <= next_pu_bank[k];
            end
        end
    end

    // Pin side: two-flop synchroniser, registered drive
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pin_meta               <= 8'h00;
            pin_sync               <= 8'h00;
            port_pin_out           <= 8'h00;
            port_pin_oe            <= 8'h00;
            port_pullup_on         <= 8'h00;
            serial_clock_in        <= 1'b0;
            serial_data_in         <= 1'b0;
            ext_serial_clock_input <= 1'b0;
        end
        else if (clk_en)
        begin
            pin_meta               <= port_pin_in;
            pin_sync               <= pin_meta;
            port_pin_out           <= next_pin_out;
            port_pin_oe            <= next_pin_oe;
            port_pullup_on         <= next_pullup_on;
            serial_clock_in        <= pin_sync[`P6G_BIT_SCL] & alt[`P6G_BIT_SCL];
            serial_data_in         <= pin_sync[`P6G_BIT_SDA] & alt[`P6G_BIT_SDA];
            // external clock input
            // At a 10 MHz sample rate a 6.4 MHz clock aliases; the peripheral
            // must run its own fast sampler if it needs every edge.
            ext_serial_clock_input <= pin_sync[`P6G_BIT_EXCLK] & alt[`P6G_BIT_EXCLK];
        end
    end

    // Pull-up bank outputs are the stored bytes; bit n feeds pin n
    assign pullup_port0  = pu_bank[0];
    assign pullup_port1  = pu_bank[1];
    assign pullup_port3  = pu_bank[2];
    assign pullup_port4  = pu_bank[3];
    assign pullup_port5  = pu_bank[4];
    assign pullup_port7  = pu_bank[5];
    assign pullup_port12 = pu_bank[6];
    assign pullup_port14 = pu_bank[7];

endmodule : p6g_port6
`default_nettype wire

// >>> p6g_port6_sva.sv
// Checker for the port 6 I/O block, watching only its top-level ports.
// Assumes binding to p6g_port6; pins pass two sync flops and one output flop.
`timescale 1ns/1ps
`default_nettype none
module p6g_port6_sva (
    input wire logic               hclk,
    input wire logic               hresetn,
    input wire logic               clk_en,
    input wire logic               hsel,
    input wire logic [31:0]        haddr,
    input wire logic [1:0]         htrans,
    input wire logic               hwrite,
    input wire logic [31:0]        hwdata,
    input wire logic               hready,
    input wire logic [7:0]         port_pin_in,
    input wire logic [7:0]         port_pin_out,
    input wire logic [7:0]         port_pin_oe,
    input wire logic [7:0]         port_pullup_on,
    input wire logic               serial_clock_in,
    input wire logic               serial_data_in,
    input wire logic               ext_serial_clock_input,
    input wire p6g_pkg::p6g_byte_t pullup_port0
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence pu0_wr;
        hsel && hready && clk_en && htrans == 2'h2 && hwrite && haddr == 32'h0003_fcc0
            ##1 hready && clk_en;
    endsequence
    a_od_low_only: assert property (port_pin_out[3:0] == 4'h0)
        else $error("open-drain pin drove high");
    a_low_no_pull: assert property (port_pullup_on[3:0] == 4'h0)
        else $error("pull-up on a lower pin");
    a_pull_input_only: assert property ((port_pullup_on[7:4] & port_pin_oe[7:4]) == 4'h0)
        else $error("pull-up on a driven pin");
    a_reset_all_in: assert property ($rose(hresetn) |-> port_pin_oe == 8'h00 ##1 port_pin_oe == 8'h00)
        else $error("pin driven right after reset");
    a_scl_gate: assert property (serial_clock_in |-> $past(port_pin_in[0], 3))
        else $error("serial clock input without pin level");
    a_sda_gate: assert property (serial_data_in |-> $past(port_pin_in[1], 3))
        else $error("serial data input without pin level");
    a_exclk_gate: assert property (ext_serial_clock_input |-> $past(port_pin_in[2], 3))
        else $error("external clock input without pin level");
    a_pu0_write: assert property (pu0_wr |=> pullup_port0 == ($past(hwdata[7:0]) & 8'h7f))
        else $error("pull-up register lost a write");
    c_pu0_write: cover property (pu0_wr);
    c_scl_seen: cover property (serial_clock_in);
    c_pull_on: cover property (port_pullup_on[7:4] != 4'h0);
endmodule : p6g_port6_sva
`default_nettype wire

// >>> port6_gpio_with_pullups_test.sv
// Self-checking bench for the port 6 I/O block with a board model on its pins.
// Assumes one 10 MHz clock; this bench is the only AHB-Lite master.
`timescale 1ns/1ps
`default_nettype none
module port6_gpio_with_pullups_test;
    import p6g_pkg::*;
    localparam logic [15:0] IDX [12] = '{16'hff30, 16'hff31, 16'hff33, 16'hff34, 16'hff35,
        16'hff37, 16'hff3c, 16'hff3e, 16'hff36, 16'hff26, 16'hff46, 16'hff06};
    localparam logic [7:0]  MSK [12] = '{8'h7f, 8'hff, 8'h0f, 8'h0f, 8'h0f, 8'hff, 8'h01,
        8'h03, 8'hf0, 8'hff, 8'h07, 8'hff};
    logic        hclk = 1'h0;
    logic        hresetn = 1'h0;
    logic        hsel = 1'h0;
    logic        hwrite = 1'h0;
    logic        scl_o = 1'h0;
    logic        sda_o = 1'h0;
    logic        exclk_on = 1'h0;
    logic        clk_en = 1'h1;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [7:0]  ext_val = 8'h00;
    logic [7:0]  ext_en = 8'hff;
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, scl_i, sda_i, exclk_i;
    wire  [7:0]  pin_in, pin_out, pin_oe, pull_on;
    wire  [7:0]  pu_o [8];
    int          error_cnt = 0;
    int          checks_done = 0;
    int          mreg [12];
    logic [31:0] rng = 32'h0000_0005;

    always #50 hclk = ~hclk;

    p6g_port6 DUT (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .port_pin_in(pin_in),
        .port_pin_out(pin_out), .port_pin_oe(pin_oe), .port_pullup_on(pull_on),
        .serial_clock_out(scl_o), .serial_data_out(sda_o), .serial_clock_in(scl_i),
        .serial_data_in(sda_i), .ext_serial_clock_input(exclk_i), .pullup_port0(pu_o[0]),
        .pullup_port1(pu_o[1]), .pullup_port3(pu_o[2]), .pullup_port4(pu_o[3]),
        .pullup_port5(pu_o[4]), .pullup_port7(pu_o[5]), .pullup_port12(pu_o[6]),
        .pullup_port14(pu_o[7]));
    p6g_board u_board (.hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe), .pull_on(pull_on),
        .ext_val(ext_val), .ext_en(ext_en), .exclk_on(exclk_on), .pin_level(pin_in));

    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : xs

    // Expected {pull, enable, drive}; lvl gives the resolved pin levels
    function automatic logic [23:0] exp_pins(output logic [7:0] lvl);
        logic [7:0] dir, lat, lv, oe, pu;
        dir = 8'(mreg[9]);
        lat = 8'(mreg[11]);
        lv  = lat & ~{6'h00, mreg[10][1] & ~sda_o, mreg[10][0] & ~scl_o};
        oe  = {~dir[7:4], ~dir[3:0] & ~lv[3:0]};
        pu  = 8'(mreg[8]) & dir & 8'hf0;
        lvl = (oe & {lat[7:4], 4'h0}) | (~oe & ((ext_en & ext_val) | (~ext_en & pu)));
        return {pu, oe, lat[7:4], 4'h0};
    endfunction : exp_pins

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic [15:0] idx, input logic wr, input logic [7:0] d,
                       output logic [31:0] r);
        hsel   <= 1'h1;
        haddr  <= {14'h0000, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        // Only the watchdog ends a wait for the slave
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        hsel   <= 1'h0;
        htrans <= 2'h0;
        hwdata <= {24'h00_0000, d};
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        r = hrdata;
    endtask : bus

    task automatic wr(input int i, input logic [7:0] d);
        logic [31:0] r;
        bus(IDX[i], 1'h1, d, r);
        mreg[i] = d & MSK[i];
    endtask : wr

    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run

    initial
    begin
        logic [31:0] r;
        logic [7:0]  lvl;
        logic [23:0] e;
        logic [3:0]  hist;
        for (int i = 0; i < 12; i++) mreg[i] = (i == 9) ? 255 : 0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        for (int i = 0; i < 11; i++)
        begin
            bus(IDX[i], 1'h0, 8'h00, r);
            chk(r, 32'(mreg[i]));
        end
        chk(32'(pin_oe), 32'h0000_0000);
        // Unmapped place: write dropped, read zero
        bus(16'hff32, 1'h1, 8'hff, r);
        bus(16'hff32, 1'h0, 8'h00, r);
        chk(r, 32'h0000_0000);
        for (int k = 0; k < 6; k++)
        begin
            r = xs();
            ext_val <= r[7:0];
            scl_o   <= r[8];
            sda_o   <= r[9];
            ext_en  <= (k == 5) ? 8'h0f : 8'hff;
            for (int i = 0; i < 12; i++) wr(i, 8'(xs()));
            if (k == 5) wr(8, 8'hf0);
            for (int i = 0; i < 11; i++)
            begin
                bus(IDX[i], 1'h0, 8'h00, r);
                chk(r, 32'(mreg[i]));
            end
            for (int j = 0; j < 8; j++) chk(32'(pu_o[j]), 32'(mreg[j]));
            repeat (6) @(posedge hclk);
            #10;
            e = exp_pins(lvl);
            chk(32'({pull_on, pin_oe, pin_out}), 32'(e));
            chk(32'({exclk_i, sda_i, scl_i}), 32'(lvl[2:0] & mreg[10][2:0]));
            @(posedge hclk);
            bus(16'hff06, 1'h0, 8'h00, r);
            chk(r, 32'((lvl & 8'(mreg[9])) | (8'(mreg[11]) & ~8'(mreg[9]))));
            chk(32'({hresp, hreadyout}), 32'h0000_0001);
        end
        // External clock runs into pin 2 with its input path enabled
        wr(9, 8'hff);
        wr(10, 8'h07);
        exclk_on <= 1'h1;
        ext_en   <= 8'hff;
        hist = 4'h0;
        for (int c = 0; c < 100; c++)
        begin
            @(posedge hclk);
            hist = {hist[2:0], pin_in[2]};
            #10;
            // Level seen at an edge shows on the input two edges later
            if (c >= 4) chk(32'(exclk_i), 32'(hist[2]));
        end
        // Clock enable low: a direction write is lost, the register keeps its value
        exclk_on <= 1'h0;
        repeat (4) @(posedge hclk);
        clk_en <= 1'h0;
        bus(IDX[9], 1'h1, 8'h00, r);
        clk_en <= 1'h1;
        @(posedge hclk);
        bus(IDX[9], 1'h0, 8'h00, r);
        chk(r, 32'(mreg[9]));
        complete_run();
    end

    initial
    begin
        #2_000_000;
        error_cnt++;
        complete_run();
    end
endmodule : port6_gpio_with_pullups_test

bind p6g_port6 p6g_port6_sva u_sva (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hready(hready), .port_pin_in(port_pin_in), .port_pin_out(port_pin_out),
    .port_pin_oe(port_pin_oe), .port_pullup_on(port_pullup_on),
    .serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in),
    .ext_serial_clock_input(ext_serial_clock_input), .pullup_port0(pullup_port0));
`default_nettype wire
